// [design/asc_pkg.sv]
// Purpose: constants for the converter sequencer control block
// Assumes: register index times four gives the apb byte address
// Notes:   one 8-bit register per aligned 32-bit word
package asc_pkg;

  // register indices (byte address = index * 4)
  localparam logic [9:0] IDX_PORT = 10'h005;
  localparam logic [9:0] IDX_INTC = 10'h00b;
  localparam logic [9:0] IDX_FLAG = 10'h00c;
  localparam logic [9:0] IDX_RESH = 10'h01e;
  localparam logic [9:0] IDX_MAIN = 10'h01f;
  localparam logic [9:0] IDX_DIR  = 10'h085;
  localparam logic [9:0] IDX_IEN  = 10'h08c;
  localparam logic [9:0] IDX_RESL = 10'h09e;
  localparam logic [9:0] IDX_AUX  = 10'h09f;

  // reset values
  localparam logic [7:0] RST_CTL  = 8'h00;
  localparam logic [7:0] RST_DIR  = 8'hff;

  // converter_control_main fields
  localparam int MAIN_EN  = 0;
  localparam int MAIN_GO  = 2;
  localparam int MAIN_CHS = 3;
  localparam int MAIN_CS  = 6;

  // converter_control_aux fields
  localparam int AUX_PCFG = 0;
  localparam int AUX_HALV = 6;
  localparam int AUX_FMT  = 7;

  // flag / enable layout
  localparam int         FLAG_DONE = 6;
  localparam logic [7:0] FLAG_MASK = 8'h4f;

  // encodings and timing counts
  localparam logic [1:0] CS_RC         = 2'h3;
  localparam logic [3:0] CMP_MODE_TRIG = 4'hb;
  localparam logic [2:0] TCY_TOSC      = 3'h4;
  localparam logic [1:0] WAIT_TAD      = 2'h2;
  localparam logic [9:0] SAR_MSB       = 10'h200;
  localparam int         RES_BITS      = 10;
  localparam int         PAD_BITS      = 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_CONV,
    ST_WAIT
  } asc_state_e;

endpackage

// [design/asc_adc_ctrl.sv]
// Purpose: register file and sequencer of a 10-bit sar converter
// Assumes: pclk is the oscillator (tosc); comparator is on pclk
// Notes:   rc tick and port pins cross in through two flops
`timescale 1ns/1ps

module asc_adc_ctrl
(
  input  wire logic        pclk,          // oscillator clock
  input  wire logic        presetn,       // async reset, low
  input  wire logic        pce,           // clock enable
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        halt,          // cpu in halt
  input  wire logic        rc_tick,       // rc oscillator
  input  wire logic        cmp_hi,        // input >= trial
  input  wire logic        ev_trigger,    // special event
  input  wire logic [3:0]  compare_mode_field, // ccu mode
  input  wire logic [7:0]  pin_in,        // port pin levels
  output logic      [7:0]  pin_out,       // port pin drive
  output logic      [7:0]  pin_oe,        // port drive enable
  output logic      [9:0]  dac_code,      // trial code
  output logic      [2:0]  channel_select,// analog mux
  output logic             adc_power,     // converter on
  output logic             sample_en,     // hold cap sampling
  output logic             conv_active,   // conversion running
  output logic             timer_reset,   // event_timer clear
  output logic             wake,          // wake from halt
  output logic             irq_req        // done & enabled
);
  import asc_pkg::*;

  // pin and rc synchronisers
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic       rc_s1_r;
  logic       rc_s2_r;
  logic       rc_s3_r;

  // registers
  logic [7:0] port_out_r;
  logic [7:0] dir_r;
  logic [7:0] intc_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] ien_r;
  logic [1:0] cs_r;
  logic [2:0] chs_r;
  logic       go_r;
  logic       go_nxt;
  logic       en_r;
  logic       fmt_r;
  logic       halv_r;
  logic [3:0] pcfg_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic [31:0] prdata_r;

  // sequencer
  asc_state_e state_r;
  asc_state_e state_nxt;
  logic [5:0] div_r;
  logic [2:0] tcy_r;
  logic [1:0] wait_r;
  logic [9:0] code_r;
  logic [9:0] bit_r;
  logic       pwr_off_r;
  logic       pwr_off_nxt;
  logic       wake_r;
  logic       tmr_rst_r;

  // analog pins per port configuration, bit order an4..an0
  function automatic logic [4:0] an_map(input logic [3:0] cfg);
    logic [4:0] m;
    m = 5'h1f;
    case (cfg)
      4'h4, 4'h5: m = 5'h0b;
      4'h6, 4'h7: m = 5'h00;
      4'hd, 4'hf: m = 5'h0f;
      4'he:       m = 5'h01;
      default:    m = 5'h1f;
    endcase
    return m;
  endfunction

  // apb decode; one register per aligned word
  wire        acc      = psel & penable & pce;
  wire        wr       = acc & pwrite;
  wire        a_ok     = (paddr[1:0] == 2'h0);
  wire [9:0]  idx      = paddr[11:2];
  wire        hit_port = a_ok & (idx == IDX_PORT);
  wire        hit_intc = a_ok & (idx == IDX_INTC);
  wire        hit_flag = a_ok & (idx == IDX_FLAG);
  wire        hit_resh = a_ok & (idx == IDX_RESH);
  wire        hit_main = a_ok & (idx == IDX_MAIN);
  wire        hit_dir  = a_ok & (idx == IDX_DIR);
  wire        hit_ien  = a_ok & (idx == IDX_IEN);
  wire        hit_resl = a_ok & (idx == IDX_RESL);
  wire        hit_aux  = a_ok & (idx == IDX_AUX);
  wire        hit      = hit_port | hit_intc | hit_flag | hit_resh | hit_main
                       | hit_dir | hit_ien | hit_resl | hit_aux;
  wire        wr_main  = wr & hit_main;
  wire [7:0]  wd       = pwdata[7:0];

  // zero wait states while pce is high; unmapped words answer with an error
  assign pready  = pce;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  // port readback masks analog pins to zero
  wire [7:0] an_mask = {3'h0, an_map(pcfg_r)};
  wire [7:0] port_rd;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign port_rd[gi] = pin_s2_r[gi] & ~an_mask[gi];
    end
  endgenerate

  wire [7:0] main_rd = {cs_r, chs_r, go_r, 1'b0, en_r};
  wire [7:0] aux_rd  = {fmt_r, halv_r, 2'h0, pcfg_r};
  wire [7:0] rd_mux  = hit_port ? port_rd
                     : hit_intc ? intc_r
                     : hit_flag ? flags_r
                     : hit_resh ? res_hi_r
                     : hit_main ? main_rd
                     : hit_dir  ? dir_r
                     : hit_ien  ? ien_r
                     : hit_resl ? res_lo_r
                     : hit_aux  ? aux_rd
                     : 8'h00;

  // bit period: tosc divider or synchronised rc edge
  wire        use_rc   = (cs_r == CS_RC);
  wire [2:0]  div_k    = {cs_r, halv_r};
  wire [6:0]  div_n    = 7'h02 << div_k;
  wire        div_last = (div_r == 6'(div_n - 7'h01));
  wire        rc_edge  = rc_s2_r & ~rc_s3_r;
  wire        tad_tick = use_rc ? rc_edge : div_last;

  // start, abort and completion terms
  wire trig_hit  = ev_trigger & (compare_mode_field == CMP_MODE_TRIG);
  wire en_drop   = wr_main & ~wd[MAIN_EN];
  // enable must already be set: a write that turns it on cannot start
  wire go_set    = en_r & ~en_drop
                 & (trig_hit | (wr_main & wd[MAIN_GO]));
  wire sw_clr    = wr_main & ~wd[MAIN_GO];
  wire running   = (state_r == ST_FIRST) | (state_r == ST_CONV);
  wire done      = (state_r == ST_CONV) & go_r & tad_tick & bit_r[0];
  wire halt_abt  = halt & ~use_rc & en_r;
  wire tcy_done  = (tcy_r == TCY_TOSC - 3'h1);
  wire [9:0] code_dec = cmp_hi ? code_r : (code_r & ~bit_r);
  wire [15:0] res_fmt = fmt_r ? {{PAD_BITS{1'b0}}, code_dec}
                              : {code_dec, {PAD_BITS{1'b0}}};

  // go: a set in the same cycle as a clear wins
  always_comb
  begin
    go_nxt = go_r;
    if (done | sw_clr | halt_abt | ~en_r)
      go_nxt = 1'b0;
    if (go_set)
      go_nxt = 1'b1;
  end

  // done flag: software write, then hardware set on top
  always_comb
  begin
    flags_nxt = flags_r;
    if (wr & hit_flag)
      flags_nxt = wd & FLAG_MASK;
    if (done)
      flags_nxt[FLAG_DONE] = 1'b1;
  end

  // power-down in halt, restored once halt ends or enable drops
  always_comb
  begin
    pwr_off_nxt = pwr_off_r;
    if (~halt | ~en_r)
      pwr_off_nxt = 1'b0;
    if (halt_abt)
      pwr_off_nxt = 1'b1;
    if (done & halt & ~ien_r[FLAG_DONE])
      pwr_off_nxt = 1'b1;
  end

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (go_r & adc_power)
          state_nxt = ST_FIRST;
      ST_FIRST:
        if (~go_r)
          state_nxt = ST_WAIT;
        else if (tcy_done & tad_tick)
          state_nxt = ST_CONV;
      ST_CONV:
        if (~go_r | done)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (tad_tick & (wait_r == WAIT_TAD - 2'h1))
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      rc_s1_r  <= 1'b0;
      rc_s2_r  <= 1'b0;
      rc_s3_r  <= 1'b0;
    end
    else if (pce)
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      rc_s1_r  <= rc_tick;
      rc_s2_r  <= rc_s1_r;
      rc_s3_r  <= rc_s2_r;
    end
  end

  // software registers; reset leaves pins an0..an4 analog
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_out_r <= RST_CTL;
      dir_r      <= RST_DIR;
      intc_r     <= RST_CTL;
      ien_r      <= RST_CTL;
      {cs_r, chs_r, en_r}    <= 6'h00;
      {fmt_r, halv_r, pcfg_r} <= 6'h00;
    end
    else if (pce)
    begin
      if (wr & hit_port) port_out_r <= wd;
      if (wr & hit_dir)  dir_r      <= wd;
      if (wr & hit_intc) intc_r     <= wd;
      if (wr & hit_ien)  ien_r      <= wd & FLAG_MASK;
      if (wr_main)
      begin
        cs_r  <= wd[MAIN_CS +: 2];
        chs_r <= wd[MAIN_CHS +: 3];
        en_r  <= wd[MAIN_EN];
      end
      if (wr & hit_aux)
      begin
        fmt_r  <= wd[AUX_FMT];
        halv_r <= wd[AUX_HALV];
        pcfg_r <= wd[AUX_PCFG +: 4];
      end
    end
  end

  // status, go and event outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_r      <= 1'b0;
      flags_r   <= RST_CTL;
      pwr_off_r <= 1'b0;
      wake_r    <= 1'b0;
      tmr_rst_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else if (pce)
    begin
      go_r      <= go_nxt;
      flags_r   <= flags_nxt;
      pwr_off_r <= pwr_off_nxt;
      wake_r    <= done & halt & ien_r[FLAG_DONE];
      tmr_rst_r <= trig_hit;
      if (psel)
        prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // sequencer state and counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      div_r   <= 6'h00;
      tcy_r   <= 3'h0;
      wait_r  <= 2'h0;
    end
    else if (pce)
    begin
      state_r <= state_nxt;
      // divider restarts with each conversion so segment one is exact
      div_r   <= (state_r == ST_IDLE | div_last) ? 6'h00 : div_r + 6'h01;
      if (state_r != ST_FIRST)
        tcy_r <= 3'h0;
      else if (!tcy_done)
        tcy_r <= tcy_r + 3'h1;
      if (state_r != ST_WAIT)
        wait_r <= 2'h0;
      else if (tad_tick)
        wait_r <= wait_r + 2'h1;
    end
  end

  // successive approximation, msb first, one bit per tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_r <= 10'h000;
      bit_r  <= 10'h000;
    end
    else if (pce)
    begin
      if (state_r == ST_FIRST)
      begin
        code_r <= SAR_MSB;
        bit_r  <= SAR_MSB;
      end
      else if (state_r == ST_CONV & tad_tick)
      begin
        code_r <= code_dec | (bit_r >> 1);
        bit_r  <= bit_r >> 1;
      end
    end
  end

  // result pair has no reset: it survives every reset untouched
  always_ff @(posedge pclk)
  begin
    if (pce)
    begin
      if (done)
        {res_hi_r, res_lo_r} <= res_fmt;
      else
      begin
        if (wr & hit_resh) res_hi_r <= wd;
        if (wr & hit_resl) res_lo_r <= wd;
      end
    end
  end

  // analog side; channel and mux ignore pin direction entirely
  assign channel_select = chs_r;
  assign adc_power      = en_r & ~pwr_off_r;
  assign sample_en      = adc_power & (state_r == ST_IDLE);
  assign conv_active    = running;
  assign dac_code       = code_r;
  assign pin_out        = port_out_r;
  assign pin_oe         = ~dir_r;
  assign timer_reset    = tmr_rst_r;
  assign wake           = wake_r;
  assign irq_req        = flags_r[FLAG_DONE] & ien_r[FLAG_DONE];

endmodule // asc_adc_ctrl

// [tb/asc_adc_ctrl_properties.sv]
// Purpose: concurrent checks on the converter sequencer ports
// Assumes: one clock domain; clock select is shadowed from bus writes
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
module asc_adc_ctrl_properties
  import asc_pkg::*;
(
  input wire logic        pclk,               // clock
  input wire logic        presetn,            // reset, low
  input wire logic        pce,                // clock enable
  input wire logic        psel,               // select
  input wire logic        penable,            // enable
  input wire logic        pwrite,             // direction
  input wire logic [11:0] paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic        halt,               // cpu halt
  input wire logic        ev_trigger,         // event
  input wire logic [3:0]  compare_mode_field, // ccu mode
  input wire logic [9:0]  dac_code,           // trial code
  input wire logic        adc_power,          // powered
  input wire logic        sample_en,          // sampling
  input wire logic        conv_active,        // converting
  input wire logic        timer_reset,        // timer clear
  input wire logic        wake,               // wake pulse
  input wire logic        irq_req             // irq level
);
  logic [1:0] cs_r;

  // clock select only changes by software, so a write shadow is exact
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cs_r <= 2'h0;
    else if (psel && penable && pwrite && pce && paddr == {IDX_MAIN, 2'h0})
      cs_r <= pwdata[7:6];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // trigger accepted and start of a conversion
  sequence s_trig;
    ev_trigger && pce && compare_mode_field == CMP_MODE_TRIG;
  endsequence
  sequence s_start;
    $rose(conv_active);
  endsequence

  AST_TIMER_CLEAR: assert property (s_trig |=> timer_reset)
    else $error("timer clear missing after trigger");
  AST_TIMER_CAUSE: assert property (timer_reset |-> $past(ev_trigger))
    else $error("timer clear without trigger");
  AST_FIRST_SEG: assert property (s_start |-> conv_active [*8])
    else $error("conversion shorter than first segment plus bits");
  AST_START_POWER: assert property (s_start |-> $past(adc_power))
    else $error("conversion started while converter off");
  AST_OFF_IDLE: assert property (!adc_power [*2] |-> !conv_active)
    else $error("conversion running while converter off");
  AST_ACQ_GAP: assert property ($fell(conv_active) |-> !sample_en [*2])
    else $error("acquisition resumed without wait");
  AST_MSB_FIRST: assert property (s_start |-> ##[1:300] dac_code == SAR_MSB)
    else $error("first trial is not the top bit");
  AST_WAKE_CAUSE: assert property (wake |-> irq_req && $past(halt))
    else $error("wake without enabled completion in halt");
  AST_HALT_ABORT: assert property (halt && cs_r != CS_RC && conv_active
    |-> ##[1:2] !conv_active && !adc_power)
    else $error("halt with oscillator clock did not abort");
  AST_RESET_STATE: assert property ($rose(presetn) |-> !adc_power && !conv_active)
    else $error("converter active after reset");
endmodule // asc_adc_ctrl_properties

bind asc_adc_ctrl asc_adc_ctrl_properties asc_adc_ctrl_properties_inst (
  .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .halt(halt), .ev_trigger(ev_trigger),
  .compare_mode_field(compare_mode_field), .dac_code(dac_code), .adc_power(adc_power),
  .sample_en(sample_en), .conv_active(conv_active), .timer_reset(timer_reset),
  .wake(wake), .irq_req(irq_req));

// [tb/asc_analog_model.sv]
// Purpose: hold capacitor and comparator in front of the sequencer
// Assumes: input level given as an ideal 10-bit code
// Notes:   comparator settles within one cycle
`timescale 1ns/1ps
module asc_analog_model
(
  input  wire logic       pclk,      // clock
  input  wire logic       sample_en, // sampling window
  input  wire logic [9:0] vin,       // input level
  input  wire logic [9:0] dac_code,  // trial code
  output logic            cmp_hi     // input >= trial
);
  logic [9:0] held_r;

  // input is held once sampling stops, so later changes are not converted
  always_ff @(posedge pclk)
    if (sample_en)
      held_r <= vin;

  // ideal comparator against the trial code
  assign cmp_hi = (held_r >= dac_code);
endmodule // asc_analog_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for the converter sequencer control block
// Assumes: pce held high; rc oscillator free running, unrelated to pclk
// Notes:   expected values are worked out by bench functions
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import asc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, halt = 1'b0, rc_tick = 1'b0, ev_trigger = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0]  pin_in = 8'h00, pin_out, pin_oe, rdat;
  logic [3:0]  mode = 4'h0;
  logic [9:0]  vin = 10'h000, dac_code;
  logic [2:0]  channel_select;
  logic [15:0] res;
  logic        pready, pslverr, cmp_hi, adc_power, sample_en, conv_active, rerr;
  logic        timer_reset, wake, irq_req, wake_seen = 1'b0;
  int          errors = 0, n_compared = 0, seed = 32'h30c6, cyc = 0, dur;

  asc_adc_ctrl asc_adc_ctrl_inst (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt(halt), .rc_tick(rc_tick), .cmp_hi(cmp_hi),
    .ev_trigger(ev_trigger), .compare_mode_field(mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .dac_code(dac_code), .channel_select(channel_select),
    .adc_power(adc_power), .sample_en(sample_en), .conv_active(conv_active),
    .timer_reset(timer_reset), .wake(wake), .irq_req(irq_req));
  asc_analog_model asc_analog_model_inst (.pclk(pclk), .sample_en(sample_en), .vin(vin),
    .dac_code(dac_code), .cmp_hi(cmp_hi));

  // 50 mhz system clock, rc oscillator near 7.7 mhz
  always #10 pclk = ~pclk;
  always #65 rc_tick = ~rc_tick;

  // hang guard and wake pulse catcher
  always @(posedge pclk)
  begin
    cyc++;
    if (wake === 1'b1)
      wake_seen = 1'b1;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk_reg(input string nm, input logic [9:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, e, rdat)
  endtask

  function automatic logic [7:0] main_v(input logic [1:0] cs, input logic go, input logic en);
    return {cs, 3'h0, go, 1'b0, en};
  endfunction

  // waits for start (bounded), end, then the return of sampling (bounded)
  task automatic run(output int d);
    int t;
    t = 0;
    d = 0;
    while (conv_active !== 1'b1 && t < 50)
    begin
      @(posedge pclk);
      t++;
    end
    while (conv_active === 1'b1)
    begin
      @(posedge pclk);
      d++;
    end
    while (sample_en !== 1'b1 && t < 400)
    begin
      @(posedge pclk);
      t++;
    end
  endtask

  // enable first, acquire, then go; result checked in the chosen format
  task automatic convert(input logic [2:0] k, input logic f, output int d);
    vin <= 10'($random(seed));
    bus(1'b1, IDX_AUX, {f, k[0], 6'h00});
    bus(1'b1, IDX_MAIN, main_v(k[2:1], 1'b0, 1'b1));
    repeat (20) @(posedge pclk);
    bus(1'b1, IDX_MAIN, main_v(k[2:1], 1'b1, 1'b1));
    run(d);
    res = f ? {6'h00, vin} : {vin, 6'h00};
    chk_reg("res_hi", IDX_RESH, res[15:8]);
    chk_reg("res_lo", IDX_RESL, res[7:0]);
  endtask

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reg("main", IDX_MAIN, RST_CTL);
    chk_reg("aux", IDX_AUX, RST_CTL);
    chk_reg("dir", IDX_DIR, RST_DIR);
    `CHK("pin_oe", 8'h00, pin_oe)
    bus(1'b0, 10'h3ff, 8'h00);
    `CHK("unmapped", 1'b1, rerr)
    // analog pins read low, digital pins read the pin
    pin_in <= 8'($random(seed));
    repeat (4) @(posedge pclk);
    chk_reg("port_an", IDX_PORT, {pin_in[7:5], 5'h00});
    bus(1'b1, IDX_AUX, 8'h06);
    chk_reg("port_dig", IDX_PORT, pin_in);
    // result pair as plain storage while disabled
    res = 16'($random(seed));
    bus(1'b1, IDX_RESH, res[15:8]);
    bus(1'b1, IDX_RESL, res[7:0]);
    chk_reg("resh_rw", IDX_RESH, res[15:8]);
    chk_reg("resl_rw", IDX_RESL, res[7:0]);
    bus(1'b1, IDX_MAIN, main_v(2'h0, 1'b1, 1'b0));
    repeat (8) @(posedge pclk);
    `CHK("no_start", 1'b0, conv_active)
    chk_reg("go_ignored", IDX_MAIN, 8'h00);
    // channel field reaches the mux, port latch reaches the pins
    bus(1'b1, IDX_MAIN, {2'h0, res[2:0], 3'h0});
    `CHK("channel", res[2:0], channel_select)
    bus(1'b1, IDX_PORT, res[15:8]);
    `CHK("pin_out", res[15:8], pin_out)
    // pins driven as outputs are converted all the same
    bus(1'b1, IDX_DIR, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      convert(3'(k), k[0], dur);
      `CHK("bit_period", 1'b1, dur >= 10 * (2 << k) && dur <= 11 * (2 << k) + 6)
      chk_reg("go_done", IDX_MAIN, main_v(2'(k >> 1), 1'b0, 1'b1));
      chk_reg("flag", IDX_FLAG, 8'h40);
      bus(1'b1, IDX_FLAG, 8'h00);
    end
    // abort in mid-conversion at the slowest divider
    bus(1'b1, IDX_MAIN, main_v(2'h2, 1'b1, 1'b1));
    repeat (100) @(posedge pclk);
    bus(1'b1, IDX_MAIN, main_v(2'h2, 1'b0, 1'b1));
    // the sequencer leaves the conversion one edge after go clears
    @(posedge pclk);
    `CHK("aborted", 1'b0, conv_active)
    `CHK("abort_wait", 1'b0, sample_en)
    chk_reg("abort_hi", IDX_RESH, res[15:8]);
    // a go written during the wait would be held back, so let it end
    run(dur);
    `CHK("abort_acq", 1'b1, sample_en)
    convert(3'h5, 1'b0, dur);
    // trigger with converter on, then off
    mode <= CMP_MODE_TRIG;
    bus(1'b1, IDX_AUX, 8'h00);
    for (int e = 1; e >= 0; e--)
    begin
      bus(1'b1, IDX_MAIN, main_v(2'h0, 1'b0, e[0]));
      repeat (20) @(posedge pclk);
      ev_trigger <= 1'b1;
      @(posedge pclk);
      ev_trigger <= 1'b0;
      @(posedge pclk);
      `CHK("timer_clear", 1'b1, timer_reset)
      chk_reg("trig_go", IDX_MAIN, main_v(2'h0, e[0], e[0]));
      run(dur);
    end
    // halt with the oscillator clock aborts and powers down; enable goes first
    bus(1'b1, IDX_MAIN, main_v(2'h0, 1'b0, 1'b1));
    repeat (20) @(posedge pclk);
    bus(1'b1, IDX_MAIN, main_v(2'h0, 1'b1, 1'b1));
    repeat (12) @(posedge pclk);
    `CHK("halt_running", 1'b1, conv_active)
    halt <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("halt_abort", 1'b0, conv_active | adc_power)
    chk_reg("halt_en", IDX_MAIN, main_v(2'h0, 1'b0, 1'b1));
    halt <= 1'b0;
    run(dur);
    // rc clock conversions in halt, interrupt enabled then disabled
    for (int ie = 1; ie >= 0; ie--)
    begin
      bus(1'b1, IDX_IEN, {1'b0, ie[0], 6'h00});
      bus(1'b1, IDX_MAIN, main_v(CS_RC, 1'b0, 1'b1));
      repeat (20) @(posedge pclk);
      wake_seen = 1'b0;
      bus(1'b1, IDX_MAIN, main_v(CS_RC, 1'b1, 1'b1));
      halt <= 1'b1;
      run(dur);
      `CHK("wake", ie[0], wake_seen)
      chk_reg("rc_done", IDX_MAIN, main_v(CS_RC, 1'b0, 1'b1));
      if (ie == 0)
        `CHK("rc_off", 1'b0, adc_power)
      halt <= 1'b0;
      bus(1'b1, IDX_FLAG, 8'h00);
    end
    // a second reset leaves the result pair alone
    res = 16'($random(seed));
    bus(1'b1, IDX_RESH, res[15:8]);
    bus(1'b1, IDX_RESL, res[7:0]);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reg("resh_kept", IDX_RESH, res[15:8]);
    chk_reg("resl_kept", IDX_RESL, res[7:0]);
    chk_reg("main_rst", IDX_MAIN, RST_CTL);
    conclude();
  end
endmodule // tb_top
